// ### hdl/cfg_reset_consts.svh
/*
 constants of the configuration word and reset sequencer: offsets, field positions,
 reset values and timing counts. assumes a 100 MHz pclk.
*/
`ifndef CFG_RESET_CONSTS_SVH
`define CFG_RESET_CONSTS_SVH

// clock rate and start-up times
`define CLK_FREQ_KHZ 100000
`define POWER_UP_DELAY_TIME_MS 64
`define POWER_UP_DELAY_CYCLES (`POWER_UP_DELAY_TIME_MS * `CLK_FREQ_KHZ)
`define OSC_STARTUP_CYCLES 1024

// register word indices; the byte address is four times the index
`define CTRL_INDEX 14'h0000
`define STATUS_INDEX 14'h0001
`define CFG_WORD_INDEX 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF

// configuration word values
`define CFG_WORD_RESET 14'h3FFF
`define CFG_UNIMPL_MASK 14'h3000

// control and status field positions
`define CTRL_SW_WATCHDOG_BIT 0
`define CTRL_SW_BROWNOUT_BIT 1
`define CTRL_SLEEP_BIT 2
`define STATUS_STATE_LSB 0
`define STATUS_CAUSE_LSB 4

// oscillator select codes that need a crystal start-up
`define OSC_LOW_POWER_XTAL 3'h0
`define OSC_XTAL 3'h1
`define OSC_HIGH_SPEED_XTAL 3'h2

// brownout select codes
`define BROWNOUT_ALWAYS 2'h3
`define BROWNOUT_RUN_ONLY 2'h2
`define BROWNOUT_SOFTWARE 2'h1
`define BROWNOUT_OFF 2'h0

`endif

// ### hdl/cfg_reset_pkg.sv
/*
 types shared by the reset sequencer: the configuration word layout, sequencer
 states and the record of the last reset cause. assumes cfg_reset_consts.svh.
*/
package cfg_reset_pkg;

   // configuration word, bit 13 down to bit 0
   typedef struct packed {
      logic [1:0] unimpl;
      logic clock_monitor_enable;
      logic clock_switchover_enable;
      logic [1:0] brownout_select;
      logic data_protect_n;
      logic program_protect_n;
      logic reset_pin_select;
      logic power_up_delay_enable_n;
      logic watchdog_enable_fuse;
      logic [2:0] osc_select;
   } cfg_word_t;

   typedef enum logic [2:0] {
      s_load,
      s_power_up_delay,
      s_osc_startup,
      s_run,
      s_sleep,
      s_hold
   } seq_state_t;

   typedef struct packed {
      logic power_on;
      logic brownout;
      logic external;
      logic watchdog;
   } reset_cause_t;

endpackage

// ### hdl/cfg_reset_seq.sv
/*
 configuration word store and reset sequencer with an apb register port.
 assumes pclk runs from the device oscillator, presetn is the power-on reset,
 and the watchdog and interrupt logic share pclk.
*/
// Behaviour
// - power-up delay holds reset 64 ms, only after power-on or brownout; power-on resets the word to unprogrammed (delay off), so brownout only
// - oscillator start-up wait holds reset until a crystal is stable
// - brownout resets the device; with the delay enabled reset lasts 64 ms
// - sleep ends on external reset, watchdog wake-up or interrupt
// - configuration bits read zero when programmed, one when not
// - configuration word at 2007h, space 2000h-3FFFh only while programming
// - top two bits of the configuration word always read one
// - bit 11 enables the clock monitor
// - bit 10 enables clock switchover
// - field order from bit 11 down as laid out in the word type
// - power-up delay enable is active low
// - brownout select: 11 on, 10 run only, 01 software, 00 off
// - reset pin select one makes pin a reset, zero a digital input
// - watchdog fuse forces watchdog on, else software bit decides
`timescale 1ns/1ns
`include "cfg_reset_consts.svh"
module cfg_reset_seq #(
   parameter int POWER_UP_DELAY_CYCLES = `POWER_UP_DELAY_CYCLES,
   parameter int OSC_STARTUP_CYCLES = `OSC_STARTUP_CYCLES,
   parameter int TIMER_W = 23
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // asynchronous pins
   input wire logic prog_mode,
   input wire logic brownout_detect,
   input wire logic osc_stable,
   input wire logic external_reset_pin_n,
   // same-clock events
   input wire logic watchdog_timeout,
   input wire logic wake_interrupt,
   // core control
   output logic core_reset_n,
   output logic core_sleep,
   output logic wake_pulse,
   output logic pin_digital_in,
   // selected options
   output logic watchdog_enable,
   output logic brownout_enable,
   output logic clock_monitor_enable,
   output logic clock_switchover_enable,
   output logic data_protect_n,
   output logic program_protect_n,
   output logic [2:0] osc_select
);
   if (POWER_UP_DELAY_CYCLES < 1 || OSC_STARTUP_CYCLES < 1 ||
       POWER_UP_DELAY_CYCLES >= (2 ** TIMER_W) || OSC_STARTUP_CYCLES >= (2 ** TIMER_W))
   begin : g_bad_params
      $error("start-up counts do not fit the timer");
   end

   cfg_reset_pkg::cfg_word_t cfg_fuse_q;
   cfg_reset_pkg::cfg_word_t cfg_q;
   cfg_reset_pkg::seq_state_t state_q;
   cfg_reset_pkg::seq_state_t state_d;
   cfg_reset_pkg::reset_cause_t cause_q;
   cfg_reset_pkg::reset_cause_t cause_d;
   logic prog_s;
   logic brownout_s;
   logic osc_ok_s;
   logic pin_s;
   logic sw_watchdog_q;
   logic sw_brownout_q;
   logic timer_done;
   logic timer_load;
   logic [TIMER_W-1:0] timer_count;
   logic go_delay;
   logic go_osc;
   logic wake_d;
   logic brownout_hit;
   logic pin_reset_hit;
   logic sleep_req;
   logic [13:0] idx;
   logic in_cfg_space;
   logic wr_fire;
   logic [31:0] rd_data;
   logic rd_err;

   // needs a crystal wait for this oscillator code
   function automatic logic needs_xtal(input logic [2:0] sel);
      needs_xtal = (sel == `OSC_LOW_POWER_XTAL) || (sel == `OSC_XTAL) ||
                   (sel == `OSC_HIGH_SPEED_XTAL);
   endfunction

   // brownout detector armed for this select code and state
   function automatic logic brownout_on(input logic [1:0] sel, input logic sw,
                                        input logic sleeping);
      case (sel)
         `BROWNOUT_ALWAYS: brownout_on = 1'b1;
         `BROWNOUT_RUN_ONLY: brownout_on = !sleeping;
         `BROWNOUT_SOFTWARE: brownout_on = sw;
         default: brownout_on = 1'b0;
      endcase
   endfunction

   // pins come from outside the clock domain; the reset pin idles high
   sync2 #(
      .W(4),
      .RST(4'h1)
   ) u_pin_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({prog_mode, brownout_detect, osc_stable, external_reset_pin_n}),
      .q({prog_s, brownout_s, osc_ok_s, pin_s})
   );

   // one timer serves both waits since they never overlap
   startup_timer #(
      .W(TIMER_W)
   ) u_startup_timer (
      .clk(pclk),
      .rst_n(presetn),
      .load(timer_load),
      .count(timer_count),
      .done_q(timer_done)
   );

   // reset requests from the detector and the pin
   assign brownout_hit = brownout_s &&
      brownout_on(cfg_q.brownout_select, sw_brownout_q, state_q == cfg_reset_pkg::s_sleep);
   assign pin_reset_hit = cfg_q.reset_pin_select && !pin_s;
   assign timer_load = go_delay || go_osc ||
      (state_q == cfg_reset_pkg::s_osc_startup && !osc_ok_s);
   assign timer_count = go_delay ? TIMER_W'(POWER_UP_DELAY_CYCLES)
                                 : TIMER_W'(OSC_STARTUP_CYCLES);

   // apb decode: word index from the byte address
   assign idx = paddr[15:2];
   assign in_cfg_space = (idx >= `CFG_SPACE_LO) && (idx <= `CFG_SPACE_HI);
   assign wr_fire = psel && penable && pready && pwrite && !pslverr;
   assign sleep_req = wr_fire && idx == `CTRL_INDEX && pwdata[`CTRL_SLEEP_BIT];

   // sequencer next state; reset requests override every state
   always_comb
   begin
      state_d = state_q;
      cause_d = cause_q;
      go_delay = 1'b0;
      go_osc = 1'b0;
      wake_d = 1'b0;
      if (brownout_hit || pin_reset_hit)
      begin
         state_d = cfg_reset_pkg::s_hold;
         cause_d = '{power_on: 1'b0, brownout: brownout_hit, external: pin_reset_hit,
                     watchdog: 1'b0};
      end
      else
      begin
         case (state_q)
            cfg_reset_pkg::s_hold: state_d = cfg_reset_pkg::s_load;
            cfg_reset_pkg::s_load:
            begin
               // the delay runs after power-on or brownout only
               if (!cfg_fuse_q.power_up_delay_enable_n &&
                   (cause_q.power_on || cause_q.brownout))
               begin
                  go_delay = 1'b1;
                  state_d = cfg_reset_pkg::s_power_up_delay;
               end
               else if (needs_xtal(cfg_fuse_q.osc_select))
               begin
                  go_osc = 1'b1;
                  state_d = cfg_reset_pkg::s_osc_startup;
               end
               else
                  state_d = cfg_reset_pkg::s_run;
            end
            cfg_reset_pkg::s_power_up_delay:
            begin
               if (timer_done && needs_xtal(cfg_q.osc_select))
               begin
                  go_osc = 1'b1;
                  state_d = cfg_reset_pkg::s_osc_startup;
               end
               else if (timer_done)
                  state_d = cfg_reset_pkg::s_run;
            end
            cfg_reset_pkg::s_osc_startup:
               if (osc_ok_s && timer_done)
                  state_d = cfg_reset_pkg::s_run;
            cfg_reset_pkg::s_run:
            begin
               if (watchdog_timeout)
               begin
                  state_d = cfg_reset_pkg::s_load;
                  cause_d = '{power_on: 1'b0, brownout: 1'b0, external: 1'b0,
                              watchdog: 1'b1};
               end
               else if (sleep_req)
                  state_d = cfg_reset_pkg::s_sleep;
            end
            cfg_reset_pkg::s_sleep:
            begin
               // external reset is taken above; here the other two causes
               if (watchdog_timeout || wake_interrupt)
               begin
                  wake_d = 1'b1;
                  go_osc = needs_xtal(cfg_q.osc_select);
                  state_d = go_osc ? cfg_reset_pkg::s_osc_startup : cfg_reset_pkg::s_run;
               end
            end
            default: state_d = cfg_reset_pkg::s_load;
         endcase
      end
   end

   // sequencer state and outputs that follow it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= cfg_reset_pkg::s_load;
         cause_q <= '{power_on: 1'b1, brownout: 1'b0, external: 1'b0, watchdog: 1'b0};
         core_reset_n <= 1'b0;
         core_sleep <= 1'b0;
         wake_pulse <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cause_q <= cause_d;
         // held one more edge after load so the latched options reach the outputs on the release edge
         core_reset_n <= ((state_d == cfg_reset_pkg::s_run) ||
                          (state_d == cfg_reset_pkg::s_sleep)) &&
                         (state_q != cfg_reset_pkg::s_load);
         core_sleep <= (state_d == cfg_reset_pkg::s_sleep);
         wake_pulse <= wake_d;
      end
   end

   // options are latched while the core is still held, so they apply from the start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_q <= cfg_reset_pkg::cfg_word_t'(`CFG_WORD_RESET);
      else if (state_q == cfg_reset_pkg::s_load)
         cfg_q <= cfg_fuse_q;
   end

   // fuse word: unprogrammed reads all ones; writable only in programming mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_fuse_q <= cfg_reset_pkg::cfg_word_t'(`CFG_WORD_RESET);
      else if (wr_fire && prog_s && idx == `CFG_WORD_INDEX)
         cfg_fuse_q <= cfg_reset_pkg::cfg_word_t'(pwdata[13:0] | `CFG_UNIMPL_MASK);
   end

   // software enables; a device reset clears them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sw_watchdog_q <= 1'b0;
         sw_brownout_q <= 1'b0;
      end
      else if (state_q == cfg_reset_pkg::s_load)
      begin
         sw_watchdog_q <= 1'b0;
         sw_brownout_q <= 1'b0;
      end
      else if (wr_fire && idx == `CTRL_INDEX)
      begin
         sw_watchdog_q <= pwdata[`CTRL_SW_WATCHDOG_BIT];
         sw_brownout_q <= pwdata[`CTRL_SW_BROWNOUT_BIT];
      end
   end

   // decoded options driven to the rest of the device
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_enable <= 1'b0;
         brownout_enable <= 1'b0;
         clock_monitor_enable <= 1'b0;
         clock_switchover_enable <= 1'b0;
         data_protect_n <= 1'b1;
         program_protect_n <= 1'b1;
         osc_select <= 3'h7;
         pin_digital_in <= 1'b0;
      end
      else
      begin
         watchdog_enable <= cfg_q.watchdog_enable_fuse || sw_watchdog_q;
         brownout_enable <= brownout_on(cfg_q.brownout_select, sw_brownout_q,
                                        state_q == cfg_reset_pkg::s_sleep);
         clock_monitor_enable <= cfg_q.clock_monitor_enable;
         clock_switchover_enable <= cfg_q.clock_switchover_enable;
         data_protect_n <= cfg_q.data_protect_n;
         program_protect_n <= cfg_q.program_protect_n;
         osc_select <= cfg_q.osc_select;
         pin_digital_in <= !cfg_q.reset_pin_select && pin_s;
      end
   end

   // read mux and error; the configuration space answers only in programming mode
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'h0)
         rd_err = 1'b1;
      else if (in_cfg_space)
      begin
         rd_err = !prog_s;
         if (prog_s && idx == `CFG_WORD_INDEX)
            rd_data = {18'h0, cfg_fuse_q};
      end
      else if (idx == `CTRL_INDEX)
      begin
         rd_data[`CTRL_SW_WATCHDOG_BIT] = sw_watchdog_q;
         rd_data[`CTRL_SW_BROWNOUT_BIT] = sw_brownout_q;
      end
      else if (idx == `STATUS_INDEX)
      begin
         rd_data[`STATUS_STATE_LSB +: 3] = state_q;
         rd_data[`STATUS_CAUSE_LSB +: 4] = cause_q;
      end
      else
         rd_err = 1'b1;
   end

   // no wait state: answer registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && !pwrite && !rd_err) ? rd_data : 32'h0000_0000;
         pslverr <= psel && !penable && rd_err;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_delay_after_power_on;
      state_q == cfg_reset_pkg::s_load && (cause_q.power_on || cause_q.brownout) &&
      !brownout_hit &&
      !pin_reset_hit && !cfg_fuse_q.power_up_delay_enable_n
      |=> state_q == cfg_reset_pkg::s_power_up_delay ##1 !core_reset_n;
   endproperty
   a_delay_after_power_on: assert property (p_delay_after_power_on)
      else $error("power-on did not start the power-up delay");

   property p_no_delay_after_watchdog;
      state_q == cfg_reset_pkg::s_load && cause_q.watchdog
      |=> state_q != cfg_reset_pkg::s_power_up_delay;
   endproperty
   a_no_delay_after_watchdog: assert property (p_no_delay_after_watchdog)
      else $error("watchdog reset started the power-up delay");

   property p_osc_holds_reset;
      state_q == cfg_reset_pkg::s_osc_startup && !osc_ok_s && !brownout_hit && !pin_reset_hit
      |=> state_q == cfg_reset_pkg::s_osc_startup && !core_reset_n;
   endproperty
   a_osc_holds_reset: assert property (p_osc_holds_reset)
      else $error("reset released before the oscillator was stable");

   property p_brownout_resets;
      brownout_hit |=> state_q == cfg_reset_pkg::s_hold && !core_reset_n && cause_q.brownout;
   endproperty
   a_brownout_resets: assert property (p_brownout_resets)
      else $error("brownout did not reset the device");

   property p_interrupt_wakes;
      state_q == cfg_reset_pkg::s_sleep && wake_interrupt && !brownout_hit && !pin_reset_hit
      |=> wake_pulse && !core_sleep;
   endproperty
   a_interrupt_wakes: assert property (p_interrupt_wakes)
      else $error("interrupt did not wake the device");

   property p_unimpl_ones;
      cfg_fuse_q.unimpl == 2'h3 && cfg_q.unimpl == 2'h3;
   endproperty
   a_unimpl_ones: assert property (p_unimpl_ones)
      else $error("unimplemented configuration bits not one");

   property p_cfg_space_locked;
      psel && !penable && paddr[1:0] == 2'h0 && in_cfg_space && !prog_s |=> pslverr && pready;
   endproperty
   a_cfg_space_locked: assert property (p_cfg_space_locked)
      else $error("configuration space answered outside programming");

   property p_latch_in_reset;
      state_q == cfg_reset_pkg::s_load |=> cfg_q == $past(cfg_fuse_q) && !core_reset_n;
   endproperty
   a_latch_in_reset: assert property (p_latch_in_reset)
      else $error("configuration not latched during reset");

   property p_pin_select;
      state_q == cfg_reset_pkg::s_run && !cfg_q.reset_pin_select && !brownout_hit &&
      !watchdog_timeout |=> core_reset_n;
   endproperty
   a_pin_select: assert property (p_pin_select)
      else $error("reset pin acted while selected as input");

   property p_watchdog_fuse;
      // skip the release edge, where the outputs still carry their reset values
      cfg_q.watchdog_enable_fuse && $past(presetn) |=> watchdog_enable;
   endproperty
   a_watchdog_fuse: assert property (p_watchdog_fuse)
      else $error("watchdog fuse did not force the watchdog on");

   property p_brownout_off;
      cfg_q.brownout_select == `BROWNOUT_OFF |=> !brownout_enable;
   endproperty
   a_brownout_off: assert property (p_brownout_off)
      else $error("brownout enabled while selected off");
endmodule

// ### hdl/startup_timer.sv
/*
 down counter shared by the power-up delay and the oscillator start-up wait.
 assumes load comes from logic on the same clock and count is at least one.
*/
`timescale 1ns/1ns
module startup_timer #(
   parameter int W = 23
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done_q
);
   logic [W-1:0] cnt_q;

   // a load restarts the wait; done holds until the next load
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end
      else if (load)
      begin
         cnt_q <= count;
         done_q <= 1'b0;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - W'(1);
         done_q <= (cnt_q == W'(1));
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // the last step of any count must raise done on the following edge
   property p_done_after_count;
      cnt_q == W'(1) && !load |=> done_q;
   endproperty
   a_done_after_count: assert property (p_done_after_count)
      else $error("timer did not expire after its count");
endmodule

// ### hdl/sync2.sv
/*
 two flip-flop synchroniser for a group of asynchronous levels.
 assumes each bit is an independent level; no bus coherence is kept.
*/
`timescale 1ns/1ns
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RST;
         q <= RST;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ### test/cfg_reset_seq_tb_top.sv
/*
 bench for cfg_reset_seq: apb access tasks and reset, start-up and sleep tests.
 assumes the design is built with start-up counts of 20 and 8 cycles.
*/
`timescale 1ns/1ns
module cfg_reset_seq_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic prog_mode, brownout_detect, osc_stable, external_reset_pin_n;
   logic watchdog_timeout, wake_interrupt, core_reset_n, core_sleep, wake_pulse;
   logic pin_digital_in, watchdog_enable, brownout_enable, clock_monitor_enable;
   logic clock_switchover_enable, data_protect_n, program_protect_n;
   logic [2:0] osc_select;
   logic [8:0] opts;
   int fail_count, checks_done, cycles, c;

   // selected options as one vector, bit 11 of the word first
   assign opts = {clock_monitor_enable, clock_switchover_enable, brownout_enable,
      watchdog_enable, data_protect_n, program_protect_n, osc_select};

   cfg_reset_seq #(.POWER_UP_DELAY_CYCLES(20), .OSC_STARTUP_CYCLES(8)) i_cfg_reset_seq (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_mode(prog_mode), .brownout_detect(brownout_detect),
      .osc_stable(osc_stable), .external_reset_pin_n(external_reset_pin_n),
      .watchdog_timeout(watchdog_timeout), .wake_interrupt(wake_interrupt),
      .core_reset_n(core_reset_n), .core_sleep(core_sleep), .wake_pulse(wake_pulse),
      .pin_digital_in(pin_digital_in), .watchdog_enable(watchdog_enable),
      .brownout_enable(brownout_enable), .clock_monitor_enable(clock_monitor_enable),
      .clock_switchover_enable(clock_switchover_enable), .data_protect_n(data_protect_n),
      .program_protect_n(program_protect_n), .osc_select(osc_select));

   // free-running 100 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         finish_test();
      end
   end

   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; exp holds {pslverr, read data}, data zero for writes
   task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [32:0] exp);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({pslverr, w ? 32'h0 : prdata}, exp);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // bounded wait for a level; the count is left in c
   task automatic wait_sig(ref logic s, input int lim);
      c = 0;
      while (s !== 1'b1 && c < lim)
      begin
         @(posedge pclk);
         c++;
      end
   endtask

   task wd_pulse;
      watchdog_timeout <= 1'b1;
      cyc(1);
      watchdog_timeout <= 1'b0;
   endtask

   // store a word through programming mode, then relatch it by a watchdog reset
   task set_fuse(input logic [31:0] v);
      prog_mode <= 1'b1;
      cyc(3);
      acc(1'b1, 16'h801C, v, 33'h0);
      prog_mode <= 1'b0;
      cyc(3);
      wd_pulse();
      // let the watchdog reset take hold before anyone waits for release
      cyc(1);
   endtask

   initial
   begin
      {psel, penable, pwrite, prog_mode, brownout_detect, osc_stable} = '0;
      {watchdog_timeout, wake_interrupt} = '0;
      paddr = '0;
      pwdata = '0;
      presetn = 1'b0;
      external_reset_pin_n = 1'b1;
      cyc(6);
      presetn <= 1'b1;
      // power-on with the unprogrammed word
      wait_sig(core_reset_n, 10);
      chk(c <= 3, 1);
      chk(opts, 9'h1FF);
      acc(1'b0, 16'h0004, 0, 33'h083);
      acc(1'b0, 16'h801C, 0, 33'h1_0000_0000);
      acc(1'b0, 16'h0002, 0, 33'h1_0000_0000);
      $display("test power_on done");
      // word store, crystal wait and pin as digital input
      prog_mode <= 1'b1;
      cyc(3);
      acc(1'b0, 16'h801C, 0, 33'h3FFF);
      acc(1'b1, 16'h801C, 32'h0100, 33'h0);
      acc(1'b0, 16'h801C, 0, 33'h3100);
      acc(1'b0, 16'h8000, 0, 33'h0);
      prog_mode <= 1'b0;
      cyc(3);
      wd_pulse();
      cyc(40);
      chk(core_reset_n, 0);
      chk(opts, 9'h000);
      osc_stable <= 1'b1;
      wait_sig(core_reset_n, 30);
      chk(c >= 8 && c < 30, 1);
      external_reset_pin_n <= 1'b0;
      cyc(5);
      chk({core_reset_n, pin_digital_in}, 2'b10);
      external_reset_pin_n <= 1'b1;
      cyc(5);
      chk(pin_digital_in, 1);
      acc(1'b1, 16'h0000, 32'h3, 33'h0);
      cyc(2);
      chk({watchdog_enable, brownout_enable}, 2'b11);
      acc(1'b0, 16'h0004, 0, 33'h013);
      $display("test config_word done");
      // delay skipped after watchdog, applied after brownout
      set_fuse(32'h3EEC);
      wait_sig(core_reset_n, 20);
      chk(c <= 8, 1);
      chk(opts, 9'h1FC);
      brownout_detect <= 1'b1;
      cyc(6);
      chk(core_reset_n, 0);
      cyc(10);
      brownout_detect <= 1'b0;
      wait_sig(core_reset_n, 60);
      chk(c >= 20 && c < 60, 1);
      acc(1'b0, 16'h0004, 0, 33'h043);
      $display("test brownout done");
      // the three ways out of sleep
      acc(1'b1, 16'h0000, 32'h4, 33'h0);
      cyc(2);
      chk({core_sleep, brownout_enable}, 2'b10);
      wake_interrupt <= 1'b1;
      wait_sig(wake_pulse, 10);
      wake_interrupt <= 1'b0;
      cyc(1);
      chk({c < 10, core_sleep}, 2'b10);
      acc(1'b1, 16'h0000, 32'h4, 33'h0);
      cyc(2);
      wd_pulse();
      wait_sig(wake_pulse, 10);
      cyc(1);
      chk({c < 10, core_sleep, core_reset_n}, 3'b101);
      acc(1'b1, 16'h0000, 32'h4, 33'h0);
      cyc(2);
      external_reset_pin_n <= 1'b0;
      cyc(6);
      chk({core_sleep, core_reset_n}, 2'b00);
      external_reset_pin_n <= 1'b1;
      wait_sig(core_reset_n, 20);
      chk(c < 20, 1);
      $display("test sleep done");
      finish_test();
   end
endmodule
